/* rtl/mms_defs.svh */
// constant offsets, bit positions, reset values and vectors of the memory map block
// assumes inclusion by the memory map module; definitions only
`ifndef MMS_DEFS_SVH
`define MMS_DEFS_SVH
`define MMS_PSW_OFF     8'hd0
`define MMS_SP_OFF      8'h81
`define MMS_SP_RST      8'h07
`define MMS_PSW_RST     8'h00
`define MMS_LOW_TOP     8'h7f
`define MMS_BITRAM_BASE 8'h20
`define MMS_RESET_VEC   16'h0000
`define MMS_VEC_FIRST   16'h0003
`define MMS_CY_BIT      7
`define MMS_AC_BIT      6
`define MMS_F0_BIT      5
`define MMS_RSH_BIT     4
`define MMS_RSL_BIT     3
`define MMS_OV_BIT      2
`define MMS_F1_BIT      1
`define MMS_P_BIT       0
`endif

/* rtl/mms_pkg.sv */
// types shared by the memory map block and its helpers
// assumes nothing beyond a SystemVerilog compiler
package mms_pkg;
   typedef enum logic [2:0] {
      MMS_OP_NONE = 3'h0,
      MMS_OP_ADD  = 3'h1,
      MMS_OP_ADDC = 3'h2,
      MMS_OP_SUBB = 3'h3,
      MMS_OP_MUL  = 3'h4,
      MMS_OP_DIV  = 3'h5,
      MMS_OP_OTHR = 3'h6
   } mms_aluop_t;
   typedef enum logic [1:0] {
      MMS_REG_APP  = 2'h0,
      MMS_REG_DATA = 2'h1,
      MMS_REG_BOOT = 2'h2
   } mms_region_t;
endpackage

/* rtl/mms_core_if.sv */
// carrier between the memory map top and its flag and flash helpers
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface mms_core_if;
   import mms_pkg::*;
   logic [7:0]  opA;
   logic [7:0]  opB;
   mms_aluop_t  op;
   logic        cyIn;
   logic        cyOut;
   logic        acOut;
   logic        ovOut;
   logic [15:0] fAddr;
   logic        fTrig;
   logic        bootRun;
   logic        bootDataEn;
   logic        fGo;
   logic        fDeny;
   modport alu   (input opA, opB, op, cyIn, output cyOut, acOut, ovOut);
   modport flash (input fAddr, fTrig, bootRun, bootDataEn, output fGo, fDeny);
endinterface

/* rtl/mms_flag_unit.sv */
// arithmetic flag evaluation for carry, half carry and overflow
// assumes operands and operation are stable in the cycle the core applies them
`timescale 1ns/1ps
module mms_flag_unit
   import mms_pkg::*;
(
   mms_core_if.alu fu
);
   logic [8:0]  sum;
   logic [4:0]  nib;
   logic [15:0] prod;
   logic        cin;

   always_comb begin
      cin      = (fu.op == MMS_OP_ADDC || fu.op == MMS_OP_SUBB) ? fu.cyIn : 1'b0;
      sum      = 9'h000;
      nib      = 5'h00;
      prod     = {8'h00, fu.opA} * {8'h00, fu.opB};
      fu.cyOut = 1'b0;
      fu.acOut = 1'b0;
      fu.ovOut = 1'b0;
      unique case (fu.op)
         MMS_OP_ADD, MMS_OP_ADDC: begin
            sum      = {1'b0, fu.opA} + {1'b0, fu.opB} + {8'h00, cin};
            nib      = {1'b0, fu.opA[3:0]} + {1'b0, fu.opB[3:0]} + {4'h0, cin};
            fu.cyOut = sum[8];                                              // [RQ13]
            fu.acOut = nib[4];                                              // [RQ14]
            fu.ovOut = (fu.opA[7] == fu.opB[7]) && (sum[7] != fu.opA[7]);  // [RQ15]
         end
         MMS_OP_SUBB: begin
            sum      = {1'b0, fu.opA} - {1'b0, fu.opB} - {8'h00, cin};
            nib      = {1'b0, fu.opA[3:0]} - {1'b0, fu.opB[3:0]} - {4'h0, cin};
            fu.cyOut = sum[8];                                              // [RQ13]
            fu.acOut = nib[4];                                              // [RQ14]
            fu.ovOut = (fu.opA[7] != fu.opB[7]) && (sum[7] != fu.opA[7]);  // [RQ15]
         end
         MMS_OP_MUL: fu.ovOut = (prod[15:8] != 8'h00);                      // [RQ15]
         MMS_OP_DIV: fu.ovOut = (fu.opB == 8'h00);                          // [RQ15]
         MMS_OP_NONE, MMS_OP_OTHR: begin
         end
      endcase
   end
endmodule

/* rtl/mms_flash_guard.sv */
// out-of-space protection for flash programming triggers
// assumes trigger is a one-cycle pulse from the core, address held beside it
`timescale 1ns/1ps
module mms_flash_guard
   import mms_pkg::*;
#(
   parameter logic [15:0] DATA_BASE = 16'h8000,
   parameter logic [15:0] BOOT_BASE = 16'hf000
)(
   input  wire logic clk,
   input  wire logic rst,
   mms_core_if.flash fl
);
   logic goQ;
   logic goD;
   logic denyQ;
   logic denyD;
   logic allow;

   function automatic mms_region_t regionOf(input logic [15:0] a);
      if (a >= BOOT_BASE) begin
         return MMS_REG_BOOT;
      end
      if (a >= DATA_BASE) begin
         return MMS_REG_DATA;
      end
      return MMS_REG_APP;
   endfunction

   always_comb begin
      unique case (regionOf(fl.fAddr))
         MMS_REG_APP:  allow = fl.bootRun;                   // [RQ2]
         MMS_REG_DATA: allow = 1'b1;                         // [RQ2]
         MMS_REG_BOOT: allow = fl.bootRun && fl.bootDataEn;  // [RQ2]
         default:      allow = 1'b0;
      endcase
      goD   = fl.fTrig && allow;   // [RQ3]
      denyD = fl.fTrig && !allow;  // [RQ3]
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         goQ   <= 1'b0;
         denyQ <= 1'b0;
      end else begin
         goQ   <= goD;
         denyQ <= denyD;
      end
   end

   assign fl.fGo   = goQ;
   assign fl.fDeny = denyQ;

   AST_APP_ONLY_BOOT: assert property (@(posedge clk) disable iff (rst) // [RQ3]
      fl.fTrig && !fl.bootRun && fl.fAddr < DATA_BASE |=> !fl.fGo && fl.fDeny)
      else $error("application region trigger from application was not refused");
endmodule

/* rtl/mms_mem_map.sv */
// memory map and status logic: scratch-pad ram, special function decode, status word,
// stack pointer, program counter entry points, flash guard and external space strobes
// assumes a single core clock; all strobes come from core logic on that clock
// Function
// (RQ1) code space is fetch-only; code may come from external space up to 64K
// (RQ2) app region only from boot; data flash from both; boot region optional
// (RQ3) a trigger aimed outside the permitted region is ignored
// (RQ4) after reset execution starts at program address 0000H
// (RQ5) interrupt vectors sit at fixed addresses eight bytes apart from 0003H
// (RQ6) 256 ram bytes plus sfr space; lower 128 reachable directly and indirectly
// (RQ7) indirect addressing of the upper 128 reaches ram only
// (RQ8) sfr space only by direct addressing, never by indirect
// (RQ9) lowest 32 bytes are four banks; register access uses the selected bank
// (RQ10) bank select 00,01,10,11 map to 00H,08H,10H,18H eight-byte blocks
// (RQ11) bit addresses 00H to 7FH cover a 128-bit ram area
// (RQ12) sfrs at addresses ending 0H or 8H are also bit addressable
// (RQ13) carry set on add carry or subtract borrow, cleared by other arithmetic
// (RQ14) half carry follows low nibble carry or borrow, else cleared
// (RQ15) overflow on signed overflow, product above 255 or divide by zero
// (RQ16) parity flag always shows odd count of accumulator ones
// (RQ17) two user flags in the status word are plain storage
// (RQ18) eight-bit stack pointer increments before each pushed byte is stored
// (RQ19) stack pointer resets to 07H so the first push lands at 08H
// (RQ20) external data space up to 64K is separate from code space
// (RQ21) direct 80H..FFH decode to sfrs, 00H..7FH to lower ram
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "mms_defs.svh"
module mms_mem_map
   import mms_pkg::*;
#(
   parameter logic [16:0] CODE_INT_BYTES = 17'h10000,
   parameter logic [15:0] DATA_BASE      = 16'h8000,
   parameter logic [15:0] BOOT_BASE      = 16'hf000
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // direct access and register port
   input  wire logic [7:0]  dirAddr,
   input  wire logic [7:0]  dirWrData,
   input  wire logic        dirWr,
   input  wire logic        dirRd,
   // indirect access
   input  wire logic [7:0]  indAddr,
   input  wire logic [7:0]  indWrData,
   input  wire logic        indWr,
   input  wire logic        indRd,
   // working registers of the selected bank
   input  wire logic [2:0]  workIdx,
   input  wire logic [7:0]  workWrData,
   input  wire logic        workWr,
   input  wire logic        workRd,
   // single-bit access
   input  wire logic [7:0]  bitAddr,
   input  wire logic        bitWrVal,
   input  wire logic        bitWr,
   input  wire logic        bitRd,
   // stack
   input  wire logic        stackPush,
   input  wire logic        stackPop,
   input  wire logic [7:0]  stackData,
   // read answers
   output logic      [7:0]  rdData,
   output logic             rdBit,
   // accumulator and arithmetic operation with its operands
   input  wire logic [7:0]  accValue,
   input  mms_aluop_t       aluOp,
   input  wire logic [7:0]  aluOpA,
   input  wire logic [7:0]  aluOpB,
   // program flow
   input  wire logic        pcStep,
   input  wire logic        pcJump,
   input  wire logic [15:0] pcTarget,
   input  wire logic        intTake,
   input  wire logic [2:0]  intNum,
   input  wire logic        extCodeOnly,
   output logic      [15:0] pcValue,
   output logic             codeExternal,
   // external data space
   input  wire logic [15:0] xdAddr,
   input  wire logic [7:0]  xdWrData,
   input  wire logic        xdWr,
   input  wire logic        xdRd,
   output logic      [15:0] xdBusAddr,
   output logic      [7:0]  xdBusData,
   output logic             xdBusWr,
   output logic             xdBusRd,
   // flash programming
   input  wire logic [15:0] flashAddr,
   input  wire logic        flashTrig,
   input  wire logic        bootRunning,
   input  wire logic        bootDataEnable,
   output logic             flashGo,
   output logic             flashDenied,
   // status view
   output logic      [7:0]  pswValue,
   output logic      [7:0]  spValue,
   output logic      [1:0]  bankSel
);
   logic [7:0]  ramQ [256];
   logic        ramWe;
   logic [7:0]  ramWa;
   logic [7:0]  ramWd;
   logic [7:0]  pswQ;
   logic [7:0]  pswD;
   logic [7:0]  spQ;
   logic [7:0]  spD;
   logic [15:0] pcQ;
   logic [15:0] pcD;
   logic [7:0]  rdQ;
   logic [7:0]  rdD;
   logic        rdBitQ;
   logic        rdBitD;
   logic [15:0] xaQ;
   logic [15:0] xaD;
   logic [7:0]  xdQ;
   logic [7:0]  xdD;
   logic        xwQ;
   logic        xrQ;
   logic [7:0]  pswLive;
   logic [7:0]  bitByte;
   logic [7:0]  bitSfr;
   mms_core_if  cif ();

   // byte address of a bit: ram bit area below 80H, sfr at the low address of its group above
   function automatic logic [7:0] bitLoc(input logic [7:0] ba);
      if (!ba[7]) begin
         return `MMS_BITRAM_BASE + {4'h0, ba[6:3]};  // [RQ11]
      end
      return {ba[7:3], 3'b000};                      // [RQ12]
   endfunction

   function automatic logic [7:0] sfrRead(input logic [7:0] a, input logic [7:0] program_status,
                                          input logic [7:0] sp);
      if (a == `MMS_PSW_OFF) begin
         return program_status;
      end
      if (a == `MMS_SP_OFF) begin
         return sp;
      end
      return 8'h00;
   endfunction

   assign pswLive = {pswQ[7:1], ^accValue};  // [RQ16]
   assign bankSel = pswQ[`MMS_RSH_BIT:`MMS_RSL_BIT];
   assign bitByte = bitLoc(bitAddr);
   assign bitSfr  = sfrRead(bitByte, pswLive, spQ);

   // single ram write port; a push takes priority so the stack never loses a byte
   always_comb begin
      ramWe = 1'b1;
      ramWa = 8'h00;
      ramWd = 8'h00;
      if (stackPush) begin
         ramWa = spQ + 8'h01;                          // [RQ18]
         ramWd = stackData;
      end else if (dirWr && dirAddr <= `MMS_LOW_TOP) begin
         ramWa = dirAddr;                              // [RQ21] [RQ6]
         ramWd = dirWrData;
      end else if (indWr) begin
         ramWa = indAddr;                              // [RQ7] [RQ8]
         ramWd = indWrData;
      end else if (workWr) begin
         ramWa = {3'b000, bankSel, workIdx};           // [RQ9] [RQ10]
         ramWd = workWrData;
      end else if (bitWr && !bitAddr[7]) begin
         ramWa = bitByte;                              // [RQ11]
         ramWd = ramQ[bitByte];
         ramWd[bitAddr[2:0]] = bitWrVal;
      end else begin
         ramWe = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (ramWe) begin
         ramQ[ramWa] <= ramWd;
      end
   end

   // status word: software writes first, arithmetic updates override them in the same cycle
   always_comb begin
      pswD = pswQ;
      if (dirWr && dirAddr == `MMS_PSW_OFF) begin
         pswD = dirWrData;                             // [RQ17]
      end
      if (bitWr && bitAddr[7] && bitByte == `MMS_PSW_OFF) begin
         pswD[bitAddr[2:0]] = bitWrVal;                // [RQ12]
      end
      unique case (cif.op)
         MMS_OP_ADD, MMS_OP_ADDC, MMS_OP_SUBB: begin
            pswD[`MMS_CY_BIT] = cif.cyOut;             // [RQ13]
            pswD[`MMS_AC_BIT] = cif.acOut;             // [RQ14]
            pswD[`MMS_OV_BIT] = cif.ovOut;             // [RQ15]
         end
         MMS_OP_MUL, MMS_OP_DIV: begin
            pswD[`MMS_CY_BIT] = 1'b0;                  // [RQ13]
            pswD[`MMS_AC_BIT] = 1'b0;                  // [RQ14]
            pswD[`MMS_OV_BIT] = cif.ovOut;             // [RQ15]
         end
         MMS_OP_OTHR: begin
            pswD[`MMS_CY_BIT] = 1'b0;                  // [RQ13]
            pswD[`MMS_AC_BIT] = 1'b0;                  // [RQ14]
         end
         MMS_OP_NONE: begin
         end
      endcase
      // parity is never stored, it is rebuilt from the accumulator on every read
      pswD[`MMS_P_BIT] = 1'b0;
   end

   // stack pointer and program counter
   always_comb begin
      spD = spQ;
      if (dirWr && dirAddr == `MMS_SP_OFF) begin
         spD = dirWrData;
      end
      if (stackPush) begin
         spD = spQ + 8'h01;                            // [RQ18]
      end else if (stackPop) begin
         spD = spQ - 8'h01;
      end
      pcD = pcQ;
      if (intTake) begin
         pcD = `MMS_VEC_FIRST + {10'h000, intNum, 3'b000};  // [RQ5]
      end else if (pcJump) begin
         pcD = pcTarget;
      end else if (pcStep) begin
         pcD = pcQ + 16'h0001;
      end
   end

   // shared read answer, valid the cycle after the strobe and held until the next read
   always_comb begin
      rdD    = rdQ;
      rdBitD = rdBitQ;
      if (dirRd) begin
         rdD = dirAddr[7] ? sfrRead(dirAddr, pswLive, spQ) : ramQ[dirAddr];  // [RQ21] [RQ8]
      end else if (indRd) begin
         rdD = ramQ[indAddr];                                                // [RQ7] [RQ8]
      end else if (workRd) begin
         rdD = ramQ[{3'b000, bankSel, workIdx}];                             // [RQ9] [RQ10]
      end else if (stackPop) begin
         rdD = ramQ[spQ];
      end
      if (bitRd) begin
         rdBitD = bitAddr[7] ? bitSfr[bitAddr[2:0]]                          // [RQ12]
                             : ramQ[bitByte][bitAddr[2:0]];                  // [RQ11]
      end
   end

   // external data strobes; code space has no write path at all
   always_comb begin
      xaD = xaQ;
      xdD = xdQ;
      if (xdWr || xdRd) begin
         xaD = xdAddr;                                 // [RQ20]
         xdD = xdWrData;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pswQ   <= `MMS_PSW_RST;
         spQ    <= `MMS_SP_RST;                        // [RQ19]
         pcQ    <= `MMS_RESET_VEC;                     // [RQ4]
         rdQ    <= 8'h00;
         rdBitQ <= 1'b0;
         xaQ    <= 16'h0000;
         xdQ    <= 8'h00;
         xwQ    <= 1'b0;
         xrQ    <= 1'b0;
      end else begin
         pswQ   <= pswD;
         spQ    <= spD;
         pcQ    <= pcD;
         rdQ    <= rdD;
         rdBitQ <= rdBitD;
         xaQ    <= xaD;
         xdQ    <= xdD;
         xwQ    <= xdWr;                               // [RQ20]
         xrQ    <= xdRd;
      end
   end

   // helpers
   assign cif.opA        = aluOpA;
   assign cif.opB        = aluOpB;
   assign cif.op         = aluOp;
   assign cif.cyIn       = pswQ[`MMS_CY_BIT];
   assign cif.fAddr      = flashAddr;
   assign cif.fTrig      = flashTrig;
   assign cif.bootRun    = bootRunning;
   assign cif.bootDataEn = bootDataEnable;

   mms_flag_unit u_flags (
      .fu (cif.alu)
   );

   mms_flash_guard #(
      .DATA_BASE (DATA_BASE),
      .BOOT_BASE (BOOT_BASE)
   ) u_guard (
      .clk (clk),
      .rst (rst),
      .fl  (cif.flash)
   );

   assign rdData       = rdQ;
   assign rdBit        = rdBitQ;
   assign pswValue     = pswLive;
   assign spValue      = spQ;
   assign pcValue      = pcQ;
   // fetches beyond on-chip flash, or all fetches when forced, go to external code space
   assign codeExternal = extCodeOnly || ({1'b0, pcQ} >= CODE_INT_BYTES);  // [RQ1]
   assign xdBusAddr    = xaQ;
   assign xdBusData    = xdQ;
   assign xdBusWr      = xwQ;
   assign xdBusRd      = xrQ;
   assign flashGo      = cif.fGo;
   assign flashDenied  = cif.fDeny;

   // checks
   AST_SP_RESET: assert property (@(posedge clk) disable iff (rst) // [RQ19]
      $past(rst) |-> spQ == 8'h07 && pcQ == 16'h0000)
      else $error("stack pointer or program counter wrong after reset");

   AST_PUSH_PREINC: assert property (@(posedge clk) disable iff (rst) // [RQ18]
      stackPush |=> spQ == $past(spQ) + 8'h01 && ramQ[spQ] == $past(stackData))
      else $error("push did not increment before storing");

   AST_PARITY_READ: assert property (@(posedge clk) disable iff (rst) // [RQ16]
      dirRd && dirAddr == 8'hd0 |=> rdData[0] == ^$past(accValue))
      else $error("parity bit does not follow accumulator");

   AST_BANK_SELECT: assert property (@(posedge clk) disable iff (rst) // [RQ10]
      workRd && !dirRd && !indRd |=> rdData == ramQ[{3'b000, $past(bankSel), $past(workIdx)}])
      else $error("working register read from wrong bank");

   AST_INDIRECT_NO_SFR: assert property (@(posedge clk) disable iff (rst) // [RQ8]
      indWr && !dirWr && !bitWr && !stackPush && !stackPop && aluOp == MMS_OP_NONE
      |=> spQ == $past(spQ) && pswQ == $past(pswQ) && ramQ[$past(indAddr)] == $past(indWrData))
      else $error("indirect write touched special function space");

   AST_VECTOR: assert property (@(posedge clk) disable iff (rst) // [RQ5]
      intTake |=> pcQ[2:0] == 3'b011 && pcQ[5:3] == $past(intNum) && pcQ[15:6] == 10'h000)
      else $error("interrupt vector not at fixed eight-byte slot");

   AST_MUL_OVERFLOW: assert property (@(posedge clk) disable iff (rst) // [RQ15]
      aluOp == MMS_OP_MUL |=> pswQ[2] == ({8'h00, $past(aluOpA)} * {8'h00, $past(aluOpB)} > 255)
                              && !pswQ[7])
      else $error("multiply overflow flag wrong");

   AST_ADD_CARRY: assert property (@(posedge clk) disable iff (rst) // [RQ13]
      aluOp == MMS_OP_ADD |=> pswQ[7] == (({1'b0, $past(aluOpA)} + {1'b0, $past(aluOpB)}) > 255))
      else $error("add carry flag wrong");

   AST_USER_FLAGS: assert property (@(posedge clk) disable iff (rst) // [RQ17]
      dirWr && dirAddr == 8'hd0 && aluOp == MMS_OP_NONE && !bitWr
      |=> pswQ[5] == $past(dirWrData[5]) && pswQ[1] == $past(dirWrData[1]))
      else $error("user flags not stored");

   AST_FLASH_DATA_OK: assert property (@(posedge clk) disable iff (rst) // [RQ2]
      flashTrig && flashAddr >= DATA_BASE && flashAddr < BOOT_BASE
      |=> flashGo && !flashDenied ##1 (!flashGo || $past(flashTrig)))
      else $error("data flash trigger was not granted as a pulse");

   COV_PUSH_POP: cover property (@(posedge clk) disable iff (rst) stackPush ##1 stackPop);
   COV_FLASH_DENY: cover property (@(posedge clk) disable iff (rst) flashDenied);
   COV_BANK3_READ: cover property (@(posedge clk) disable iff (rst) workRd && bankSel == 2'b11);
   COV_DIV_ZERO: cover property (@(posedge clk) disable iff (rst)
      aluOp == MMS_OP_DIV && aluOpB == 8'h00);
endmodule

/* dv/mms_cpu_model.sv */
// cpu datapath stand-in: one arithmetic step per request, accumulator loaded from operand a
// assumes requests arrive on the core clock, one cycle each
`timescale 1ns/1ps
module mms_cpu_model
   import mms_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // request from the bench
   input  wire logic       aluGo,
   input  mms_aluop_t      opIn,
   input  wire logic [7:0] aIn,
   input  wire logic [7:0] bIn,
   // towards the memory map
   output mms_aluop_t      aluOp,
   output logic      [7:0] aluOpA,
   output logic      [7:0] aluOpB,
   output logic      [7:0] accValue
);
   logic [7:0] acc_q;
   // operands are inverted outside a request so stale values never look live
   always_comb begin
      aluOp = aluGo ? opIn : MMS_OP_NONE;
      aluOpA = aluGo ? aIn : ~aIn;
      aluOpB = aluGo ? bIn : ~bIn;
      accValue = acc_q;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_q <= 8'h00;
      end else if (aluGo) begin
         acc_q <= aIn;
      end
   end
endmodule

/* dv/mms_mem_map_bench.sv */
// self-checking bench of the memory map block; notes queued by the driver, checked by a monitor
// assumes the block answers one cycle after each taken strobe
`timescale 1ns/1ps
module mms_mem_map_bench
   import mms_pkg::*;
;
   logic        clk;
   logic        rst;
   logic [7:0]  dirAddr, dirWrData, indAddr, indWrData, workWrData, bitAddr, stackData;
   logic [7:0]  rdData, aIn, bIn, accValue, aluOpA, aluOpB, xdWrData, xdBusData;
   logic [7:0]  pswValue, spValue;
   logic [2:0]  workIdx, intNum;
   logic [15:0] pcTarget, pcValue, xdAddr, xdBusAddr, flashAddr;
   logic [1:0]  bankSel;
   logic        bitWrVal, rdBit, extCodeOnly, codeExternal, xdBusWr, xdBusRd;
   logic        bootRunning, bootDataEnable, flashGo, flashDenied;
   logic        dirWr, dirRd, indWr, indRd, workWr, workRd, bitWr, bitRd, stackPush;
   logic        stackPop, pcStep, pcJump, intTake, xdWr, xdRd, flashTrig, aluGo;
   mms_aluop_t  aluOp, opIn;
   logic [16:0] stb;
   logic        pend = 1'b0;
   logic [19:0] note;
   logic [15:0] seen;
   logic [19:0] q[$];
   int          err_count = 0;
   int          n_tests = 0;
   // one-hot strobe word: a single assignment per edge keeps requests back to back
   assign {aluGo, flashTrig, xdRd, xdWr, intTake, pcJump, pcStep, stackPop, stackPush,
           bitRd, bitWr, workRd, workWr, indRd, indWr, dirRd, dirWr} = stb;
   mms_mem_map u_dut (.*);
   mms_cpu_model u_cpu (.*);
   always #2.5 clk = ~clk;
   task automatic chk(input string what, input logic [15:0] s, input logic [15:0] e);
      n_tests++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic op(input int n, input logic [15:0] w, input logic [7:0] d);
      @(posedge clk);
      stb <= 17'(1) << n;
      {dirAddr, indAddr, bitAddr, aIn} <= {4{w[7:0]}};
      {workIdx, intNum} <= {2{w[2:0]}};
      {xdAddr, flashAddr, pcTarget} <= {3{w}};
      {dirWrData, indWrData, workWrData, stackData, xdWrData, bIn} <= {6{d}};
      bitWrVal <= d[0];
   endtask
   task automatic nte(input logic [3:0] k, input logic [15:0] v);
      q.push_back({k, v});
   endtask
   function automatic logic [3:0] flg(mms_aluop_t o, logic [7:0] a, logic [7:0] b,
                                      logic [3:0] p);
      logic [8:0] s;
      logic       c;
      c = (o == MMS_OP_ADD) ? 1'b0 : p[3];
      s = (o == MMS_OP_SUBB) ? {1'b0, a} - {1'b0, b} - 9'(c) : {1'b0, a} + {1'b0, b} + 9'(c);
      flg[0] = ^a;
      case (o)
         MMS_OP_ADD, MMS_OP_ADDC: flg[3:1] = {s[8], 5'(a[3:0]) + 5'(b[3:0]) + 5'(c) > 5'h0f,
                                              a[7] == b[7] && s[7] != a[7]};
         MMS_OP_SUBB: flg[3:1] = {s[8], 5'(a[3:0]) < 5'(b[3:0]) + 5'(c),
                                  a[7] != b[7] && s[7] != a[7]};
         MMS_OP_MUL: flg[3:1] = {2'b00, 16'(a) * 16'(b) > 16'h00ff};
         MMS_OP_DIV: flg[3:1] = {2'b00, b == 8'h00};
         default: flg[3:1] = {2'b00, p[1]};
      endcase
   endfunction
   // every read-like strobe yields exactly one answer in the following cycle
   always @(posedge clk) pend <= |(stb & 17'h1feaa);
   always @(negedge clk) begin
      if (pend) begin
         note = q.pop_front();
         case (note[19:16])
            4'h0: seen = {8'h00, rdData};
            4'h1: seen = {15'h0000, rdBit};
            4'h2: seen = {14'h0000, flashGo, flashDenied};
            4'h3: seen = {12'h000, pswValue[7:6], pswValue[2], pswValue[0]};
            4'h4: seen = pcValue;
            default: seen = {xdBusWr, xdBusRd, xdBusData, xdBusAddr[5:0]};
         endcase
         chk("answer", seen, note[15:0]);
      end
   end
   initial begin
      #20000;
      err_count++;
      test_done();
   end
   initial begin
      logic [7:0]  d, a, bb;
      logic [15:0] w;
      logic [3:0]  f;
      logic [2:0]  i;
      logic        g;
      mms_aluop_t  o;
      clk = 1'b0;
      rst = 1'b1;
      stb = '0;
      {dirAddr, dirWrData, indAddr, indWrData, workWrData, bitAddr, stackData} = '0;
      {workIdx, intNum, bitWrVal, extCodeOnly, bootRunning, bootDataEnable} = '0;
      {pcTarget, xdAddr, xdWrData, flashAddr, aIn, bIn} = '0;
      opIn = MMS_OP_NONE;
      void'($urandom(32'ha4da));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("sp", {8'h00, spValue}, 16'h0007);
      chk("pc", pcValue, 16'h0000);
      chk("psw", {5'h00, codeExternal, flashGo, flashDenied, pswValue}, 16'h0000);
      d = 8'($urandom);
      op(8, 16'h0000, d);
      op(1, 16'h0081, 8'h00); nte(0, 16'h0008);
      op(1, 16'h0008, 8'h00); nte(0, {8'h00, d});
      op(9, 16'h0000, 8'h00); nte(0, {8'h00, d});
      op(1, 16'h0081, 8'h00); nte(0, 16'h0007);
      $display("stack test done");
      for (int b = 0; b < 4; b++) begin
         d = 8'($urandom);
         i = 3'($urandom);
         op(0, 16'h00d0, {3'h0, b[1:0], 3'h0});
         op(4, {13'h0000, i}, d);
         #1 chk("bank", {14'h0000, bankSel}, {14'h0000, b[1:0]});
         op(1, {11'h000, b[1:0], i}, 8'h00); nte(0, {8'h00, d});
      end
      $display("bank test done");
      op(0, 16'h0021, 8'h00);
      op(6, 16'h000b, 8'h01);
      op(1, 16'h0021, 8'h00); nte(0, 16'h0008);
      op(7, 16'h000b, 8'h00); nte(1, 16'h0001);
      op(0, 16'h00d0, 8'h00);
      op(6, 16'h00d5, 8'h01);
      op(6, 16'h00d1, 8'h01);
      op(1, 16'h00d0, 8'h00); nte(0, 16'h0022);
      $display("bit test done");
      d = 8'($urandom);
      op(2, 16'h0090, d);
      op(1, 16'h0090, 8'h00); nte(0, 16'h0000);
      op(3, 16'h0090, 8'h00); nte(0, {8'h00, d});
      op(2, 16'h00d0, ~d);
      op(1, 16'h00d0, 8'h00); nte(0, 16'h0022);
      op(0, 16'h0040, ~d);
      op(3, 16'h0040, 8'h00); nte(0, {8'h00, ~d});
      $display("addressing test done");
      f = 4'h0;
      for (int k = 0; k < 12; k++) begin
         o = mms_aluop_t'(3'(k % 6 + 1));
         {a, bb} = 16'($urandom);
         if (k == 0) {a, bb} = 16'h8080;
         if (k == 3) {a, bb} = 16'h1010;
         if (k == 4) bb = 8'h00;
         f = flg(o, a, bb, f);
         op(16, {8'h00, a}, bb);
         opIn <= o;
         nte(3, {12'h000, f});
      end
      $display("flag test done");
      for (int k = 0; k < 8; k++) begin
         w = 16'($urandom);
         if (k > 3) w[15:12] = 4'hf;
         if (k < 2) w[15:12] = 4'(k * 9);
         g = (w >= 16'hf000) ? (k[1] & k[0]) : ((w >= 16'h8000) | k[1]);
         op(15, w, 8'h00);
         {bootRunning, bootDataEnable} <= k[1:0];
         nte(2, {14'h0000, g, ~g});
      end
      $display("flash test done");
      for (int k = 0; k < 8; k++) begin
         op(12, 16'(k), 8'h00); nte(4, 16'h0003 + 16'(k) * 16'h0008);
      end
      w = 16'($urandom);
      op(11, w, 8'h00); nte(4, w);
      op(10, 16'h0000, 8'h00); nte(4, w + 16'h0001);
      d = 8'($urandom);
      op(13, w, d); nte(5, {2'b10, d, w[5:0]});
      op(14, ~w, d); nte(5, {2'b01, d, ~w[5:0]});
      @(posedge clk);
      stb <= '0;
      extCodeOnly <= 1'b1;
      @(posedge clk);
      #1;
      chk("codeExternal", {15'h0000, codeExternal}, 16'h0001);
      $display("program test done");
      repeat (3) @(posedge clk);
      chk("queue", 16'(q.size()), 16'h0000);
      test_done();
   end
endmodule
